/* File: verilog/rvt_pkg.sv */
package rvt_pkg;

  localparam int          RVT_AW          = 24;
  localparam logic [23:0] RVT_RESET_ADDR  = 24'h000000;
  localparam logic [23:0] RVT_JUMP_TARGET = 24'h000002;
  localparam logic [23:0] RVT_PRI_BASE    = 24'h000004;
  localparam logic [23:0] RVT_ALT_BASE    = 24'h000104;
  localparam logic [23:0] RVT_PRI_IRQ0    = 24'h000014;
  localparam logic [23:0] RVT_PRI_IRQ117  = 24'h0000FE;
  localparam logic [23:0] RVT_ALT_IRQ0    = 24'h000114;
  localparam logic [23:0] RVT_ALT_IRQ117  = 24'h0001FE;
  localparam logic [23:0] RVT_CODE_START  = 24'h000200;
  localparam logic [23:0] RVT_PC_STEP     = 24'h000002;
  localparam int          RVT_NUM_VEC     = 126;
  localparam int          RVT_NUM_TRAP    = 8;
  localparam logic [6:0]  RVT_TRAP_OSC    = 7'h01;
  localparam logic [6:0]  RVT_TRAP_ADDR   = 7'h02;
  localparam logic [6:0]  RVT_TRAP_STACK  = 7'h03;
  localparam logic [6:0]  RVT_TRAP_MATH   = 7'h04;

  typedef enum logic [2:0] {
    RVT_ST_RUN,
    RVT_ST_VEC_REQ,
    RVT_ST_VEC_WAIT,
    RVT_ST_JUMP
  } rvt_state_t;

  // fetch request toward program memory
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic        is_vector;
  } rvt_fetch_t;

  typedef struct packed {
    logic [6:0]  vec_num;
    logic        active;
  } rvt_vec_t;

endpackage

/* File: verilog/rvt_vector_unit.sv */
// Functional notes
// - reset enters directly, independent of trap or interrupt pending inputs.
// - reset clears all state, forcing program counter to zero.
// - first fetch after reset is from address 0x000000.
// - primary table: reserved, four traps, three reserved, from 0x000004.
// - interrupt vector 0 at 0x000014, vector 117 at 0x0000FE.
// - alternate table mirrors from 0x000104; code starts at 0x000200.
// - lowest numbered pending vector has highest natural priority.
// - alternate select steers all vectoring to the alternate table.
// - each vector word holds a 24-bit start address loaded into counter.
module rvt_vector_unit
  import rvt_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        alt_table_select,
  input  wire logic [rvt_pkg::RVT_NUM_VEC-1:0] vec_pending,
  input  wire logic                        advance,
  input  wire logic                        mem_ready,
  input  wire logic [23:0]                 mem_rdata,
  output rvt_pkg::rvt_fetch_t              fetch,
  output logic [23:0]                      program_counter,
  output rvt_pkg::rvt_vec_t                vec_ack
);
  import rvt_pkg::*;

  typedef struct packed {
    rvt_state_t  state;
    logic [23:0] pc;
    logic [6:0]  vec_num;
    logic        vec_active;
    logic [23:0] fetch_addr;
    logic        fetch_vec;
  } rvt_regs_t;

  rvt_regs_t   s_r;
  rvt_regs_t   s_nxt;
  logic        any_pend;
  logic [6:0]  win_num;
  logic        trap_any;
  logic [2:0]  trap_idx;
  logic        irq_any;
  logic [6:0]  irq_idx;
  logic [23:0] vec_addr;

  // traps sit below every interrupt in the table, so a pending trap always
  // outranks an interrupt; each group picks its own lowest index
  rvt_first_set #(
    .WIDTH (RVT_NUM_TRAP),
    .IDXW  (3)
  ) trap_pick_u (
    .req   (vec_pending[RVT_NUM_TRAP-1:0]),
    .found (trap_any),
    .index (trap_idx)
  );

  rvt_first_set #(
    .WIDTH (RVT_NUM_VEC - RVT_NUM_TRAP),
    .IDXW  (7)
  ) irq_pick_u (
    .req   (vec_pending[RVT_NUM_VEC-1:RVT_NUM_TRAP]),
    .found (irq_any),
    .index (irq_idx)
  );

  always_comb begin
    any_pend = trap_any | irq_any;
    if (trap_any) begin
      win_num = {4'h0, trap_idx};
    end else begin
      win_num = irq_idx + 7'(RVT_NUM_TRAP);
    end
  end

  // trap slots 0..7 and interrupts 8..125 share one linear index, so the
  // layout of traps and interrupt words falls out of base plus 2*n
  rvt_vec_addr addr_u (
    .alt_sel (alt_table_select),
    .vec_num (win_num),
    .addr    (vec_addr)
  );

  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      RVT_ST_RUN: begin
        s_nxt.fetch_vec  = 1'b0;
        s_nxt.fetch_addr = s_r.pc;
        s_nxt.vec_active = 1'b0;
        if (any_pend) begin
          s_nxt.state      = RVT_ST_VEC_REQ;
          s_nxt.vec_num    = win_num;
          s_nxt.fetch_vec  = 1'b1;
          s_nxt.fetch_addr = vec_addr;
        end else if (advance) begin
          s_nxt.pc         = s_r.pc + RVT_PC_STEP;
          s_nxt.fetch_addr = s_r.pc + RVT_PC_STEP;
        end
      end
      RVT_ST_VEC_REQ: begin
        s_nxt.state = RVT_ST_VEC_WAIT;
      end
      RVT_ST_VEC_WAIT: begin
        if (mem_ready) begin
          s_nxt.pc         = mem_rdata;
          s_nxt.fetch_addr = mem_rdata;
          s_nxt.fetch_vec  = 1'b0;
          s_nxt.vec_active = 1'b1;
          s_nxt.state      = RVT_ST_JUMP;
        end
      end
      RVT_ST_JUMP: begin
        s_nxt.vec_active = 1'b0;
        s_nxt.state      = RVT_ST_RUN;
      end
      default: begin
        s_nxt.state = RVT_ST_RUN;
      end
    endcase
  end

  // reset is plain state clearing, never a vector fetch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r.state      <= RVT_ST_RUN;
      s_r.pc         <= RVT_RESET_ADDR;
      s_r.vec_num    <= 7'h00;
      s_r.vec_active <= 1'b0;
      s_r.fetch_addr <= RVT_RESET_ADDR;
      s_r.fetch_vec  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fetch.valid      = ~sys_rst;
  assign fetch.addr       = s_r.fetch_addr;
  assign fetch.is_vector  = s_r.fetch_vec;
  assign program_counter  = s_r.pc;
  assign vec_ack.vec_num  = s_r.vec_num;
  assign vec_ack.active   = s_r.vec_active;

endmodule // rvt_vector_unit

// finds the lowest set request bit; bit 0 has the highest natural priority
module rvt_first_set #(
  parameter int WIDTH = 8,
  parameter int IDXW  = 3
) (
  input  wire logic [WIDTH-1:0] req,
  output logic                  found,
  output logic [IDXW-1:0]       index
);

  // scanning downward lets the lowest set bit overwrite any higher one
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = IDXW'(i);
      end
    end
  end

endmodule // rvt_first_set

// forms the program memory word address of one vector entry
module rvt_vec_addr
  import rvt_pkg::*;
(
  input  wire logic        alt_sel,
  input  wire logic [6:0]  vec_num,
  output logic [23:0]      addr
);
  import rvt_pkg::*;

  logic [23:0] base;

  // both tables share one layout, so only the base differs
  always_comb begin
    base = alt_sel ? RVT_ALT_BASE : RVT_PRI_BASE;
    addr = base + {16'h0000, vec_num, 1'b0};
  end

endmodule // rvt_vec_addr

/* File: bench/rvt_sva.sv */
module rvt_sva import rvt_pkg::*; (
  input wire logic clk_sys, sys_rst, mem_ready, alt_table_select,
  input wire logic [RVT_NUM_VEC-1:0] vec_pending,
  input wire logic [23:0] mem_rdata, program_counter,
  input rvt_pkg::rvt_fetch_t fetch,
  input rvt_pkg::rvt_vec_t vec_ack
);
  wire v = fetch.is_vector, k = vec_ack.active;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_rdy; v && mem_ready && $past(v); endsequence
  property p_r; disable iff (1'b0) sys_rst |-> !fetch.valid ##1 program_counter == 0; endproperty
  a_r: assert property (p_r) else $error("r");
  property p_l; s_rdy |=> program_counter == $past(mem_rdata) && k; endproperty
  a_l: assert property (p_l) else $error("l");
  property p_k; k |=> !k; endproperty
  a_k: assert property (p_k) else $error("k");
  property p_f; $fell(sys_rst) |-> fetch.addr == RVT_RESET_ADDR && !v; endproperty
  a_f: assert property (p_f) else $error("first fetch not at reset address");
  property p_h; v && !mem_ready |=> v && $stable(fetch.addr); endproperty
  a_h: assert property (p_h) else $error("vector fetch dropped early");
  property p_a; $rose(v) |-> fetch.addr == ($past(alt_table_select) ? RVT_ALT_BASE
    : RVT_PRI_BASE) + {16'h0000, vec_ack.vec_num, 1'b0}; endproperty
  a_a: assert property (p_a) else $error("vector address wrong");
  property p_p; $rose(v) |->
    ($past(vec_pending) & ((126'h1 << vec_ack.vec_num) - 126'h1)) == 126'h0; endproperty
  a_p: assert property (p_p) else $error("lower vector was pending");
endmodule // rvt_sva

/* File: bench/rvt_mem_model.sv */
module rvt_mem_model import rvt_pkg::*; (
  input wire logic clk_sys,
  input rvt_pkg::rvt_fetch_t fetch,
  output logic mem_ready,
  output logic [23:0] mem_rdata
);
  logic [2:0] wait_r;
  always_ff @(posedge clk_sys) wait_r <= fetch.is_vector && !mem_ready ? wait_r + 3'h1 : 3'h0;
  // delay varies with address, never before the second edge
  assign mem_ready = fetch.is_vector && wait_r == 3'(fetch.addr[2:1]) + 3'h1;
  // every entry holds a handler address; the reset word jumps via 0x000002
  assign mem_rdata = mem_ready ? fetch.addr + 24'h800000 :
                     (fetch.addr == RVT_RESET_ADDR) ? RVT_JUMP_TARGET : ~fetch.addr;
endmodule // rvt_mem_model

/* File: bench/reset_vector_table_map_tb.sv */
module reset_vector_table_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rvt_pkg::*;
  logic clk_sys = 0, sys_rst = 1, alt_table_select = 0, advance = 0, mem_ready;
  logic [125:0] vec_pending = '0;
  logic [23:0] mem_rdata, program_counter;
  rvt_fetch_t fetch;
  rvt_vec_t vec_ack;
  int compares = 0, miscompares = 0;
  rvt_vector_unit dut_u (.*);
  rvt_mem_model mem_u (.*);
  initial forever #2 clk_sys = ~clk_sys;
  task chk(input logic [23:0] a, e);
    compares++;
    if (a !== e) begin
      miscompares++;
      $display("unexpected %0t %h %h", $time, a, e);
    end
  endtask
  task report_and_stop;
    $display("%0d compares %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_rst;
    advance <= 1'b1;
    vec_pending <= 126'h8;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    vec_pending <= '0;
    repeat (3) @(posedge clk_sys);
    advance <= 1'b0;
    @(negedge clk_sys);
    chk(program_counter, 24'h000006);
    $display("rst end");
  endtask
  task t_mid;
    @(posedge clk_sys);
    vec_pending <= 126'h100;
    @(posedge clk_sys);
    vec_pending <= '0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk(program_counter, RVT_RESET_ADDR);
    chk({23'h0, fetch.is_vector}, 24'h0);
    chk({23'h0, fetch.valid}, 24'h1);
    $display("mid rst end");
  endtask
  task vec(input int n, m, input logic a, input logic [23:0] ea);
    @(posedge clk_sys);
    alt_table_select <= a;
    vec_pending <= 126'h1 << n | 126'h1 << m;
    @(posedge clk_sys);
    vec_pending <= '0;
    repeat (9) @(negedge clk_sys) if (vec_ack.active === 1'b1) break;
    chk(program_counter, ea + 24'h800000);
    chk(fetch.addr, ea + 24'h800000);
    chk(24'(vec_ack.vec_num), 24'(n));
    $display("vec end");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    t_rst();
    vec(2, 4, 1'b0, 24'h000008);
    vec(8, 125, 1'b0, RVT_PRI_IRQ0);
    vec(125, 125, 1'b0, RVT_PRI_IRQ117);
    t_mid();
    vec(125, 125, 1'b1, RVT_ALT_IRQ117);
    vec(0, 8, 1'b1, RVT_ALT_BASE);
    report_and_stop();
  end
  initial begin
    #1600;
    miscompares++;
    report_and_stop();
  end
endmodule // reset_vector_table_map_tb
bind rvt_vector_unit rvt_sva chk_u (.*);
